/* File: hdl/lse_pkg.sv */
// Constants for the load and store stall event counter.
`default_nettype none
package lse_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] COUNT_OFFSET  = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  localparam int EVT_LSB    = 0;
  localparam int UMASK_LSB  = 8;
  localparam int ENABLE_BIT = 16;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [7:0] EVT_LOAD_BLOCK  = 8'h03;
  localparam logic [7:0] EVT_STORE_BLOCK = 8'h04;
  localparam logic [7:0] UM_OVERLAP      = 8'h08;
  localparam logic [7:0] UM_UNTIL_RETIRE = 8'h10;
  localparam logic [7:0] UM_FIRST_LEVEL  = 8'h20;
  localparam logic [7:0] UM_DRAIN        = 8'h01;
  localparam logic [7:0] UM_ORDER        = 8'h02;
  localparam logic [7:0] UM_SNOOP        = 8'h08;
  localparam logic [12:0] LINE_BYTES  = 13'h0040;
  localparam logic [12:0] CHUNK_BYTES = 13'h0008;
  localparam logic [4:0]  WIDE_LOAD_BYTES = 5'h10;
  localparam int ST_RETIRE  = 0;
  localparam int ST_L1      = 1;
  localparam int ST_OVERLAP = 2;
  localparam int ST_DRAIN   = 3;
  localparam int ST_ORDER   = 4;
  localparam int ST_SNOOP   = 5;
  localparam int ST_WAIT    = 6;
  localparam int ST_RESUB   = 7;
  localparam int ST_W       = 8;
endpackage
`default_nettype wire

/* File: hdl/lse_event_counter.sv */
// Stall event qualification, load hold tracking and one counter behind APB.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module lse_event_counter #(
  parameter int MISS_W     = 4,
  parameter int MAX_MISSES = 8
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [lse_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           load_valid,
  input  wire logic [lse_pkg::ADDR_W-1:0]     load_addr,
  input  wire logic [4:0]                     load_size,
  input  wire logic                           load_uncacheable,
  input  wire logic                           load_io,
  input  wire logic                           load_held_other,
  input  wire logic                           load_locked_active,
  input  wire logic [MISS_W-1:0]              demand_misses,
  input  wire logic [MISS_W-1:0]              swpf_misses,
  input  wire logic [MISS_W-1:0]              hwpf_misses,
  input  wire logic                           older_store_valid,
  input  wire logic [lse_pkg::ADDR_W-1:0]     store_addr,
  input  wire logic [4:0]                     store_size,
  input  wire logic                           store_same_page,
  input  wire logic                           store_retired_committed,
  input  wire logic                           drain_serialize,
  input  wire logic                           drain_sync,
  input  wire logic                           drain_intr_ack,
  input  wire logic                           drain_cache_flush,
  input  wire logic                           drain_other,
  input  wire logic                           order_wait_start,
  input  wire logic                           order_observed,
  input  wire logic                           order_bus_read,
  input  wire logic                           snoop_response,
  input  wire logic                           store_port_snoop,
  input  wire logic                           store_pending,
  output logic                                load_wait_store,
  output logic                                store_order_stall,
  output logic                                store_resubmit,
  output logic                                count_tick
);

  typedef struct packed {
    logic [7:0]  evt;
    logic [7:0]  umask;
    logic        enable;
    logic [31:0] count;
    logic        tick;
    logic        wait_load;
    logic        order_stall;
    logic        bus_pending;
    logic        resubmit;
    logic        ready;
    logic        err;
    logic [31:0] rdata;
  } lse_state_type;

  lse_state_type state_reg;
  lse_state_type state_next;

  // True when a span of bytes starting at the given offset crosses a boundary.
  function automatic logic lse_crosses(input logic [12:0] ofs, input logic [4:0] size,
                                       input logic [12:0] bound);
    logic [12:0] last;
    last = ofs + {8'h00, size} - 13'h0001;
    return (size != 5'h00) && ((ofs / bound) != (last / bound));
  endfunction

  localparam int ST_W_C = lse_pkg::ST_W;

  logic [12:0]       l_start;
  logic [12:0]       l_end;
  logic [12:0]       s_start;
  logic [12:0]       s_end;
  logic              any_overlap;
  logic              full_cover;
  logic              store_misaligned;
  logic              line_split;
  logic [MISS_W+1:0] miss_total;
  logic              hit_partial;
  logic              hit_misaligned;
  logic              hit_chunk_split;
  logic              hit_alias;
  logic              cond_retire;
  logic              cond_l1;
  logic              cond_overlap;
  logic              cond_drain;
  logic              cond_snoop;
  logic              order_end;
  logic              sel_hit;
  logic              acc;
  logic              cnt_wr;
  logic [ST_W_C-1:0] status;

  always_comb begin
    l_start = {1'b0, load_addr};
    l_end   = l_start + {8'h00, load_size};
    s_start = {1'b0, store_addr};
    s_end   = s_start + {8'h00, store_size};
    any_overlap      = store_same_page && (l_start < s_end) && (s_start < l_end);
    full_cover       = store_same_page && (l_start >= s_start) && (l_end <= s_end);
    store_misaligned = (s_start & ({8'h00, store_size} - 13'h0001)) != 13'h0000;
    line_split       = lse_crosses(l_start, load_size, lse_pkg::LINE_BYTES);
    miss_total = {2'b00, demand_misses} + {2'b00, swpf_misses} + {2'b00, hwpf_misses};
    hit_partial     = any_overlap && !full_cover;
    hit_misaligned  = full_cover && store_misaligned && (l_start != s_start);
    hit_chunk_split = lse_crosses(l_start, load_size, lse_pkg::CHUNK_BYTES)
                      && (load_size != lse_pkg::WIDE_LOAD_BYTES);
    hit_alias       = !store_same_page && (load_addr == store_addr);
    cond_overlap = load_valid && older_store_valid
                   && (hit_partial || hit_misaligned || hit_chunk_split || hit_alias);
    // Counting every cycle a held load is presented can overcount, never undercount.
    cond_retire = load_valid && (load_uncacheable || line_split || load_held_other);
    cond_l1 = load_valid && ((miss_total > (MISS_W+2)'(MAX_MISSES)) || line_split
              || load_uncacheable || load_io || load_locked_active);
    cond_drain = drain_serialize || drain_sync || drain_intr_ack
                 || drain_cache_flush || drain_other;
    cond_snoop = store_port_snoop && store_pending;
    order_end = order_observed || (state_reg.bus_pending && snoop_response);
  end

  always_comb begin
    sel_hit = 1'b0;
    if (state_reg.evt == lse_pkg::EVT_LOAD_BLOCK) begin
      case (state_reg.umask)
        lse_pkg::UM_UNTIL_RETIRE: sel_hit = cond_retire;
        lse_pkg::UM_FIRST_LEVEL:  sel_hit = cond_l1;
        lse_pkg::UM_OVERLAP:      sel_hit = cond_overlap;
        default:                  sel_hit = 1'b0;
      endcase
    end else if (state_reg.evt == lse_pkg::EVT_STORE_BLOCK) begin
      case (state_reg.umask)
        lse_pkg::UM_DRAIN: sel_hit = cond_drain;
        lse_pkg::UM_ORDER: sel_hit = state_reg.order_stall;
        lse_pkg::UM_SNOOP: sel_hit = cond_snoop;
        default:           sel_hit = 1'b0;
      endcase
    end
  end

  assign acc    = psel && penable && !state_reg.ready;
  assign cnt_wr = psel && penable && state_reg.ready && pwrite && !state_reg.err
                  && (paddr == lse_pkg::COUNT_OFFSET);
  assign status = {state_reg.resubmit, state_reg.wait_load, cond_snoop,
                   state_reg.order_stall, cond_drain, cond_overlap, cond_l1, cond_retire};

  always_comb begin
    state_next = state_reg;
    state_next.ready = acc;
    state_next.tick  = 1'b0;
    state_next.err   = 1'b0;
    state_next.rdata = 32'h0000_0000;
    if (acc) begin
      state_next.err   = 1'b0;
      state_next.rdata = 32'h0000_0000;
      case (paddr)
        lse_pkg::CTRL_OFFSET: state_next.rdata = {15'h0000, state_reg.enable,
                                                  state_reg.umask, state_reg.evt};
        lse_pkg::COUNT_OFFSET:  state_next.rdata = state_reg.count;
        lse_pkg::STATUS_OFFSET: state_next.rdata = {24'h00_0000, status};
        default:                state_next.err = 1'b1;
      endcase
      if (pwrite) begin
        state_next.rdata = 32'h0000_0000;
      end
    end
    // Writes take effect only at the completing edge, so a stalled master never double-writes.
    if (psel && penable && state_reg.ready && pwrite && !state_reg.err
        && (paddr == lse_pkg::CTRL_OFFSET)) begin
      state_next.evt    = pwdata[lse_pkg::EVT_LSB +: 8];
      state_next.umask  = pwdata[lse_pkg::UMASK_LSB +: 8];
      state_next.enable = pwdata[lse_pkg::ENABLE_BIT];
    end
    // A software write to the count wins over an increment in the same cycle.
    if (cnt_wr) begin
      state_next.count = pwdata;
    end else if (state_reg.enable && sel_hit) begin
      state_next.count = state_reg.count + 32'h0000_0001;
      state_next.tick  = 1'b1;
    end
    state_next.wait_load = cond_overlap
                           || (state_reg.wait_load && !store_retired_committed);
    state_next.order_stall = order_wait_start || (state_reg.order_stall && !order_end);
    state_next.bus_pending = (order_bus_read && (state_reg.order_stall || order_wait_start))
                             || (state_reg.bus_pending && !order_end);
    state_next.resubmit = cond_snoop;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= '0;
      state_reg.evt    <= lse_pkg::CTRL_RESET[lse_pkg::EVT_LSB +: 8];
      state_reg.umask  <= lse_pkg::CTRL_RESET[lse_pkg::UMASK_LSB +: 8];
      state_reg.enable <= lse_pkg::CTRL_RESET[lse_pkg::ENABLE_BIT];
      state_reg.count  <= lse_pkg::COUNT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata            = state_reg.rdata;
  assign pready            = state_reg.ready;
  assign pslverr           = state_reg.err;
  assign load_wait_store   = state_reg.wait_load;
  assign store_order_stall = state_reg.order_stall;
  assign store_resubmit    = state_reg.resubmit;
  assign count_tick        = state_reg.tick;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic cfg_on;
  assign cfg_on = state_reg.enable && !cnt_wr;

  property p_retire_uncached;
    cfg_on && state_reg.evt == 8'h03 && state_reg.umask == 8'h10
    && load_valid && load_uncacheable |=> state_reg.count == $past(state_reg.count) + 32'h1;
  endproperty
  a_retire_uncached: assert property (p_retire_uncached) else $error("Held load not counted.");

  property p_retire_split;
    cfg_on && state_reg.evt == 8'h03 && state_reg.umask == 8'h10 && load_valid
    && load_addr[5:0] == 6'h3F && load_size == 5'h02 |=> count_tick;
  endproperty
  a_retire_split: assert property (p_retire_split) else $error("Line split load not counted.");

  property p_l1_locked;
    cfg_on && state_reg.evt == 8'h03 && state_reg.umask == 8'h20
    && load_valid && load_locked_active |=> state_reg.count == $past(state_reg.count) + 32'h1;
  endproperty
  a_l1_locked: assert property (p_l1_locked) else $error("Locked load block missed.");

  property p_partial;
    load_valid && older_store_valid && store_same_page && load_addr == store_addr
    && load_size == 5'h08 && store_size == 5'h04 |=> load_wait_store;
  endproperty
  a_partial: assert property (p_partial) else $error("Partial overlap not held.");

  property p_alias;
    load_valid && older_store_valid && !store_same_page && load_addr == store_addr
    |=> load_wait_store;
  endproperty
  a_alias: assert property (p_alias) else $error("Page alias not held.");

  sequence s_held_open;
    load_wait_store && !store_retired_committed && !cond_overlap;
  endsequence
  sequence s_held_close;
    store_retired_committed && !cond_overlap;
  endsequence
  property p_hold;
    (s_held_open |=> load_wait_store) and (s_held_close |=> !load_wait_store);
  endproperty
  a_hold: assert property (p_hold) else $error("Load hold released wrongly.");

  property p_drain;
    cfg_on && state_reg.evt == 8'h04 && state_reg.umask == 8'h01 && drain_cache_flush
    |=> state_reg.count == $past(state_reg.count) + 32'h1;
  endproperty
  a_drain: assert property (p_drain) else $error("Drain cycle not counted.");

  property p_order;
    order_wait_start |=> store_order_stall;
  endproperty
  a_order: assert property (p_order) else $error("Ordering stall not raised.");

  sequence s_bus_read;
    store_order_stall && order_bus_read && !order_wait_start
    ##1 snoop_response && !order_wait_start;
  endsequence
  property p_snoop_end;
    s_bus_read |=> !store_order_stall;
  endproperty
  a_snoop_end: assert property (p_snoop_end) else $error("Stall outlived snoop response.");

  property p_snoop_count;
    cfg_on && state_reg.evt == 8'h04 && state_reg.umask == 8'h08
    && store_port_snoop && store_pending |=> count_tick;
  endproperty
  a_snoop_count: assert property (p_snoop_count) else $error("Snoop stall not counted.");

  property p_resubmit;
    store_port_snoop && store_pending |=> store_resubmit;
  endproperty
  a_resubmit: assert property (p_resubmit) else $error("Store not resubmitted.");

  property p_unmatched;
    !cnt_wr && (state_reg.evt != 8'h03) && (state_reg.evt != 8'h04) |=> $stable(state_reg.count);
  endproperty
  a_unmatched: assert property (p_unmatched) else $error("Unmatched event counted.");

  property p_retire_other;
    cfg_on && state_reg.evt == 8'h03 && state_reg.umask == 8'h10
    && load_valid && load_held_other |=> count_tick;
  endproperty
  a_retire_other: assert property (p_retire_other) else $error("Other held load missed.");

  property p_l1_partial_read;
    cfg_on && state_reg.evt == 8'h03 && state_reg.umask == 8'h20
    && load_valid && (load_uncacheable || load_io) |=> count_tick;
  endproperty
  a_l1_partial_read: assert property (p_l1_partial_read) else $error("Partial read missed.");

  property p_misaligned;
    load_valid && older_store_valid && store_same_page && store_addr[1:0] == 2'h2
    && store_size == 5'h04 && load_addr == store_addr + 12'h001 && load_size == 5'h01
    |=> load_wait_store;
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("Misaligned store not held.");

  property p_chunk_split;
    load_valid && older_store_valid && load_addr[2:0] == 3'h6 && load_size == 5'h04
    |=> load_wait_store;
  endproperty
  a_chunk_split: assert property (p_chunk_split) else $error("Chunk split not held.");

  property p_drain_causes;
    cfg_on && state_reg.evt == 8'h04 && state_reg.umask == 8'h01
    && (drain_serialize || drain_sync || drain_intr_ack || drain_other) |=> count_tick;
  endproperty
  a_drain_causes: assert property (p_drain_causes) else $error("Drain cause missed.");

  property p_order_count;
    cfg_on && state_reg.evt == 8'h04 && state_reg.umask == 8'h02 && store_order_stall
    |=> count_tick;
  endproperty
  a_order_count: assert property (p_order_count) else $error("Order stall not counted.");

  property p_observed_end;
    store_order_stall && order_observed && !order_wait_start |=> !store_order_stall;
  endproperty
  a_observed_end: assert property (p_observed_end) else $error("Stall outlived observe.");

  property p_disabled;
    !state_reg.enable && !cnt_wr |=> $stable(state_reg.count);
  endproperty
  a_disabled: assert property (p_disabled) else $error("Disabled counter moved.");

  property p_tick_step;
    count_tick |-> state_reg.count == $past(state_reg.count) + 32'h1;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("Tick without one step.");

endmodule
`default_nettype wire

/* File: verif/lse_tb.sv */
// Self-checking testbench for the load and store stall event counter.
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [13:0] fl;
    logic [11:0] la;
    logic [4:0]  ls;
    logic [11:0] sa;
    logic [4:0]  ss;
    logic [11:0] miss;
    logic        exp;
    logic        hold;
  } lse_row_type;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, load_addr, store_addr;
  logic [31:0] pwdata, prdata, rdv;
  logic [4:0]  load_size, store_size;
  logic [3:0]  demand_misses, swpf_misses, hwpf_misses;
  logic        load_valid, load_uncacheable, load_io, load_held_other, load_locked_active;
  logic        older_store_valid, store_same_page, store_retired_committed;
  logic        drain_serialize, drain_sync, drain_intr_ack, drain_cache_flush, drain_other;
  logic        order_wait_start, order_observed, order_bus_read, snoop_response;
  logic        store_port_snoop, store_pending, erv;
  logic        load_wait_store, store_order_stall, store_resubmit, count_tick;
  int          fails, cmp_count;
  lse_row_type idle = '0;
  // Each row presents its condition for exactly one cycle.
  lse_row_type rows [0:23] = '{
    '{32'h0001_1003, 14'h0003, 12'h100, 5'h04, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_1003, 14'h0001, 12'h03C, 5'h08, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_1003, 14'h0009, 12'h100, 5'h04, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_1003, 14'h0001, 12'h100, 5'h04, 12'h000, 5'h00, 12'h000, 1'b0, 1'b0},
    '{32'h0001_2003, 14'h0001, 12'h100, 5'h04, 12'h000, 5'h00, 12'h333, 1'b1, 1'b0},
    '{32'h0001_2003, 14'h0001, 12'h100, 5'h04, 12'h000, 5'h00, 12'h233, 1'b0, 1'b0},
    '{32'h0001_2003, 14'h0005, 12'h100, 5'h01, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_2003, 14'h0011, 12'h100, 5'h04, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_2003, 14'h0001, 12'h03E, 5'h04, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_0803, 14'h0061, 12'h100, 5'h08, 12'h104, 5'h04, 12'h000, 1'b1, 1'b1},
    '{32'h0001_0803, 14'h0061, 12'h103, 5'h01, 12'h102, 5'h04, 12'h000, 1'b1, 1'b1},
    '{32'h0001_0803, 14'h0061, 12'h206, 5'h04, 12'h800, 5'h04, 12'h000, 1'b1, 1'b1},
    '{32'h0001_0803, 14'h0061, 12'h208, 5'h10, 12'h800, 5'h04, 12'h000, 1'b0, 1'b0},
    '{32'h0001_0803, 14'h0021, 12'h300, 5'h04, 12'h300, 5'h04, 12'h000, 1'b1, 1'b1},
    '{32'h0001_0803, 14'h0061, 12'h400, 5'h08, 12'h400, 5'h08, 12'h000, 1'b0, 1'b0},
    '{32'h0001_0104, 14'h0080, 12'h000, 5'h00, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_0104, 14'h0100, 12'h000, 5'h00, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_0104, 14'h0200, 12'h000, 5'h00, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_0104, 14'h0400, 12'h000, 5'h00, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_0104, 14'h0800, 12'h000, 5'h00, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_0804, 14'h3000, 12'h000, 5'h00, 12'h000, 5'h00, 12'h000, 1'b1, 1'b0},
    '{32'h0001_0804, 14'h1000, 12'h000, 5'h00, 12'h000, 5'h00, 12'h000, 1'b0, 1'b0},
    '{32'h0001_0105, 14'h0080, 12'h000, 5'h00, 12'h000, 5'h00, 12'h000, 1'b0, 1'b0},
    '{32'h0000_0104, 14'h0080, 12'h000, 5'h00, 12'h000, 5'h00, 12'h000, 1'b0, 1'b0}
  };
  lse_event_counter #(.MISS_W(4), .MAX_MISSES(8)) i_lse_event_counter (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .load_valid(load_valid), .load_addr(load_addr), .load_size(load_size),
    .load_uncacheable(load_uncacheable), .load_io(load_io), .load_held_other(load_held_other),
    .load_locked_active(load_locked_active), .demand_misses(demand_misses),
    .swpf_misses(swpf_misses), .hwpf_misses(hwpf_misses), .older_store_valid(older_store_valid),
    .store_addr(store_addr), .store_size(store_size), .store_same_page(store_same_page),
    .store_retired_committed(store_retired_committed), .drain_serialize(drain_serialize),
    .drain_sync(drain_sync), .drain_intr_ack(drain_intr_ack), .drain_other(drain_other),
    .drain_cache_flush(drain_cache_flush), .order_wait_start(order_wait_start),
    .order_observed(order_observed), .order_bus_read(order_bus_read),
    .snoop_response(snoop_response), .store_port_snoop(store_port_snoop),
    .store_pending(store_pending), .load_wait_store(load_wait_store),
    .store_order_stall(store_order_stall), .store_resubmit(store_resubmit),
    .count_tick(count_tick)
  );
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // The wait is bounded so that a slave that never answers cannot hang the run.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) fails++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_in(input lse_row_type r);
    {store_pending, store_port_snoop, drain_other, drain_cache_flush} <= r.fl[13:10];
    {drain_intr_ack, drain_sync, drain_serialize, store_same_page} <= r.fl[9:6];
    {older_store_valid, load_locked_active, load_held_other} <= r.fl[5:3];
    {load_io, load_uncacheable, load_valid} <= r.fl[2:0];
    {demand_misses, swpf_misses, hwpf_misses} <= r.miss;
    load_addr <= r.la;
    load_size <= r.ls;
    store_addr <= r.sa;
    store_size <= r.ss;
  endtask
  task automatic run_row(input lse_row_type r);
    apb(1'b1, lse_pkg::CTRL_OFFSET, r.ctrl);
    apb(1'b1, lse_pkg::COUNT_OFFSET, 32'h0000_0000);
    @(posedge pclk);
    set_in(r);
    @(posedge pclk);
    set_in(idle);
    #1;
    check(count_tick, r.exp);
    check(store_resubmit, r.fl[12] & r.fl[13]);
    check(load_wait_store, r.hold);
    repeat (2) @(posedge pclk);
    #1;
    check(load_wait_store, r.hold);
    apb(1'b0, lse_pkg::STATUS_OFFSET, 32'h0000_0000);
    check(rdv, {25'h0000000, r.hold, 6'h00});
    @(posedge pclk);
    store_retired_committed <= 1'b1;
    @(posedge pclk);
    store_retired_committed <= 1'b0;
    #1;
    check(load_wait_store, 32'h0);
    apb(1'b0, lse_pkg::COUNT_OFFSET, 32'h0000_0000);
    check(rdv, {31'h0, r.exp});
  endtask
  // The stall is counted from its registered flag, so three stalled cycles give three.
  task automatic order_run(input logic bus);
    apb(1'b1, lse_pkg::CTRL_OFFSET, 32'h0001_0204);
    apb(1'b1, lse_pkg::COUNT_OFFSET, 32'h0000_0000);
    @(posedge pclk);
    order_wait_start <= 1'b1;
    @(posedge pclk);
    order_wait_start <= 1'b0;
    order_bus_read <= bus;
    #1;
    check(store_order_stall, 32'h1);
    @(posedge pclk);
    order_bus_read <= 1'b0;
    @(posedge pclk);
    order_observed <= ~bus;
    snoop_response <= bus;
    #1;
    check(store_order_stall, 32'h1);
    @(posedge pclk);
    order_observed <= 1'b0;
    snoop_response <= 1'b0;
    #1;
    check(store_order_stall, 32'h0);
    apb(1'b0, lse_pkg::COUNT_OFFSET, 32'h0000_0000);
    check(rdv, 32'h0000_0003);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, store_retired_committed} = '0;
    {order_wait_start, order_observed, order_bus_read, snoop_response} = '0;
    set_in(idle);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check({load_wait_store, store_order_stall, store_resubmit, count_tick}, 32'h0);
    apb(1'b0, lse_pkg::CTRL_OFFSET, 32'h0000_0000);
    check(rdv, lse_pkg::CTRL_RESET);
    apb(1'b0, lse_pkg::COUNT_OFFSET, 32'h0000_0000);
    check(rdv, lse_pkg::COUNT_RESET);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check({erv, rdv[30:0]}, 32'h8000_0000);
    foreach (rows[i]) run_row(rows[i]);
    order_run(1'b0);
    order_run(1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lse_pkg::CTRL_OFFSET, 32'h0000_0000);
    check(rdv, lse_pkg::CTRL_RESET);
    apb(1'b0, lse_pkg::COUNT_OFFSET, 32'h0000_0000);
    check(rdv, lse_pkg::COUNT_RESET);
    tally_and_finish();
  end
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
